// *** verilog/srxef_top.sv ***
`timescale 1ns/100ps
// How it works
// R1 - Receiver disable leaves overrun flag unchanged.
// R2 - Overrun keeps old character, drops new.
// R3 - Overrun flag halts reception; sync halts transmit.
// R4 - Framing error sets status bit 4.
// R5 - Framing flag cleared by read-1-write-0 only.
// R6 - Receiver disable leaves framing flag unchanged.
// R7 - Two stop bits: only first checked.
// R8 - Framing error loads holding register, no full.
// R9 - Framing flag halts further reception.
// R10 - Sync mode framing flag stops both directions.
// R11 - Completion while full raises overrun flag.
// R12 - Overrun flag cleared by read-1-write-0 only.
// R13 - Full flag set only on normal completion.
module srxef_top
  import srxef_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} srxef_rx_t;
  typedef struct packed {
    srxef_rx_t rx;
    logic [7:0] rx_shift_reg;
    logic [3:0] bitn;
    logic stop_seen;
    logic [7:0] rx_holding_reg;
    logic rx_full_flag;
    logic overrun_err_flag;
    logic framing_err_flag;
    logic rx_full_flag_armed;
    logic oer_armed;
    logic fer_armed;
    logic [3:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic ack;
    logic irq;
    logic tx_start;
    logic [7:0] tx_data;
  } srxef_st_t;
  srxef_st_t st_ff, nxt_st;
  logic tick, restart, tx_txd, tx_busy, tx_hold, err_block;
  logic rx_done, rx_frame_ok, wr_stat, rd_stat;
  logic [7:0] first_cnt;
  logic [2:0] ev;

  // Either error flag blocks reception; in sync mode it also freezes transmit.
  assign err_block = st_ff.overrun_err_flag | st_ff.framing_err_flag; // [R3] [R9]
  assign tx_hold = err_block & st_ff.ctrl[SRXEF_CTRL_SYNC]; // [R3] [R10]
  assign restart = (st_ff.rx == RX_IDLE) & ~rxd;
  assign first_cnt = SRXEF_HALF_CLKS;
  assign wr_stat = avs_write & st_ff.ack & (avs_address == SRXEF_ADDR_STAT);
  assign rd_stat = avs_read & st_ff.ack & (avs_address == SRXEF_ADDR_STAT);

  srxef_bitclk u_bitclk (
    .clk(clk),
    .srst(srst),
    .restart(restart),
    .first_cnt(first_cnt),
    .tick(tick)
  );

  srxef_txser u_tx (
    .clk(clk),
    .srst(srst),
    .tick(tick),
    .start(st_ff.tx_start),
    .data(st_ff.tx_data),
    .hold(tx_hold),
    .txd(tx_txd),
    .busy(tx_busy)
  );

  // Only the first stop bit is sampled; a second stop bit is idle time.
  assign rx_done = (st_ff.rx == RX_STOP) & tick; // [R7]
  assign rx_frame_ok = rxd;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_start = 1'b0;
    ev = 3'h0;
    nxt_st.ack = (avs_read | avs_write) & ~st_ff.ack;
    unique case (st_ff.rx)
      RX_IDLE: begin
        if (~rxd && st_ff.ctrl[SRXEF_CTRL_RE] && !err_block) begin // [R3] [R9]
          nxt_st.rx = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          nxt_st.rx = rxd ? RX_IDLE : RX_DATA;
          nxt_st.bitn = 4'h0;
        end
      end
      RX_DATA: begin
        if (tick) begin
          nxt_st.rx_shift_reg = {rxd, st_ff.rx_shift_reg[7:1]};
          nxt_st.bitn = st_ff.bitn + 4'h1;
          if (st_ff.bitn == SRXEF_DATA_BITS - 4'h1) begin
            nxt_st.rx = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          nxt_st.rx = RX_IDLE;
          nxt_st.stop_seen = rx_frame_ok;
        end
      end
    endcase
    // Clearing flags: a read that returned 1 arms the later 0-write.
    if (rd_stat) begin
      nxt_st.rx_full_flag_armed = st_ff.rx_full_flag;
      nxt_st.oer_armed = st_ff.overrun_err_flag;
      nxt_st.fer_armed = st_ff.framing_err_flag;
    end
    if (wr_stat) begin
      if (st_ff.rx_full_flag_armed && !avs_writedata[SRXEF_ST_RX_FULL_FLAG]) begin
        nxt_st.rx_full_flag = 1'b0;
      end
      if (st_ff.oer_armed && !avs_writedata[SRXEF_ST_ORER]) begin // [R12]
        nxt_st.overrun_err_flag = 1'b0;
      end
      if (st_ff.fer_armed && !avs_writedata[SRXEF_ST_FRER]) begin // [R5]
        nxt_st.framing_err_flag = 1'b0;
      end
      nxt_st.rx_full_flag_armed = 1'b0;
      nxt_st.oer_armed = 1'b0;
      nxt_st.fer_armed = 1'b0;
    end
    if (avs_read && st_ff.ack && avs_address == SRXEF_ADDR_DATA) begin
      nxt_st.rx_full_flag = 1'b0;
    end
    // Completion events come after the clears so that a set wins.
    if (rx_done) begin
      if (st_ff.rx_full_flag) begin
        nxt_st.overrun_err_flag = 1'b1; // [R11] [R2]
        ev[SRXEF_IRQ_OVR] = 1'b1;
      end else if (!rx_frame_ok) begin
        nxt_st.framing_err_flag = 1'b1; // [R4]
        nxt_st.rx_holding_reg = st_ff.rx_shift_reg; // [R8]
        ev[SRXEF_IRQ_FRM] = 1'b1;
      end else begin
        nxt_st.rx_holding_reg = st_ff.rx_shift_reg;
        nxt_st.rx_full_flag = 1'b1; // [R13]
        ev[SRXEF_IRQ_RXF] = 1'b1;
      end
    end
    if (avs_write && st_ff.ack) begin
      unique case (avs_address)
        // Writing RE=0 touches only ctrl; the error flags are left alone.
        SRXEF_ADDR_CTRL: nxt_st.ctrl = avs_writedata[3:0]; // [R1] [R6]
        SRXEF_ADDR_IRQ_STAT: nxt_st.irq_stat = st_ff.irq_stat & ~avs_writedata[2:0];
        SRXEF_ADDR_IRQ_MASK: nxt_st.irq_mask = avs_writedata[2:0];
        SRXEF_ADDR_TXDATA: begin
          if (st_ff.ctrl[SRXEF_CTRL_TE] && !tx_busy && !tx_hold) begin // [R10]
            nxt_st.tx_data = avs_writedata[7:0];
            nxt_st.tx_start = 1'b1;
          end
        end
        default: ;
      endcase
    end
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    nxt_st.rdata = 32'h0000_0000;
    if (avs_read && !st_ff.ack) begin
      unique case (avs_address)
        SRXEF_ADDR_CTRL: nxt_st.rdata = {28'h0, st_ff.ctrl};
        SRXEF_ADDR_STAT: nxt_st.rdata = {24'h0, 1'b0, st_ff.rx_full_flag, st_ff.overrun_err_flag,
                                         st_ff.framing_err_flag, 3'h0, tx_busy};
        SRXEF_ADDR_DATA: nxt_st.rdata = {24'h0, st_ff.rx_holding_reg};
        SRXEF_ADDR_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.irq_stat};
        SRXEF_ADDR_IRQ_MASK: nxt_st.rdata = {29'h0, st_ff.irq_mask};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end else if (st_ff.ack) begin
      nxt_st.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.rx <= RX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Output flops: txd comes from the transmitter register, the rest from st_ff.
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = ~st_ff.ack;
  assign irq = st_ff.irq;
  assign txd = tx_txd;

  property p_oer_keeps_data;
    @(posedge clk) disable iff (srst)
      (rx_done && st_ff.rx_full_flag) |=> (st_ff.overrun_err_flag && $stable(st_ff.rx_holding_reg));
  endproperty
  a_oer_keeps_data: assert property (p_oer_keeps_data) else $error("overrun changed data"); // [R2]

  property p_oer_set;
    @(posedge clk) disable iff (srst) (rx_done && st_ff.rx_full_flag) |=> st_ff.overrun_err_flag;
  endproperty
  a_oer_set: assert property (p_oer_set) else $error("overrun flag not set"); // [R11]

  property p_no_rx_on_err;
    @(posedge clk) disable iff (srst) (st_ff.rx == RX_IDLE && err_block) |=> st_ff.rx == RX_IDLE;
  endproperty
  a_no_rx_on_err: assert property (p_no_rx_on_err) else $error("reception while error"); // [R3] [R9]

  property p_fer_set;
    @(posedge clk) disable iff (srst)
      (rx_done && !st_ff.rx_full_flag && !rxd) |=> (st_ff.framing_err_flag && !st_ff.rx_full_flag);
  endproperty
  a_fer_set: assert property (p_fer_set) else $error("framing handling wrong"); // [R4] [R8]

  property p_fer_no_clear;
    @(posedge clk) disable iff (srst) (st_ff.framing_err_flag && !st_ff.fer_armed) |=> st_ff.framing_err_flag;
  endproperty
  a_fer_no_clear: assert property (p_fer_no_clear) else $error("framing flag lost"); // [R5] [R6]

  property p_oer_no_clear;
    @(posedge clk) disable iff (srst) (st_ff.overrun_err_flag && !st_ff.oer_armed) |=> st_ff.overrun_err_flag;
  endproperty
  a_oer_no_clear: assert property (p_oer_no_clear) else $error("overrun flag lost"); // [R1] [R12]

  property p_full_only_ok;
    @(posedge clk) disable iff (srst) $rose(st_ff.rx_full_flag) |-> $past(rx_done && rxd);
  endproperty
  a_full_only_ok: assert property (p_full_only_ok) else $error("full set wrongly"); // [R13]

  property p_sync_tx_hold;
    @(posedge clk) disable iff (srst) tx_hold |=> !st_ff.tx_start;
  endproperty
  a_sync_tx_hold: assert property (p_sync_tx_hold) else $error("transmit during error"); // [R10]

  property p_stop1_only;
    @(posedge clk) disable iff (srst) rx_done |=> st_ff.rx == RX_IDLE;
  endproperty
  a_stop1_only: assert property (p_stop1_only) else $error("second stop checked"); // [R7]

  c_overrun: cover property (@(posedge clk) $rose(st_ff.overrun_err_flag));
  c_framing: cover property (@(posedge clk) $rose(st_ff.framing_err_flag));
  c_full: cover property (@(posedge clk) $rose(st_ff.rx_full_flag));
  c_fer_clear: cover property (@(posedge clk) $fell(st_ff.framing_err_flag));
endmodule // srxef_top

// *** verilog/srxef_pkg.sv ***
package srxef_pkg;
  // Word offsets on the Avalon-MM slave (byte address = 4 * index).
  localparam logic [2:0] SRXEF_ADDR_CTRL = 3'h0;
  localparam logic [2:0] SRXEF_ADDR_STAT = 3'h1;
  localparam logic [2:0] SRXEF_ADDR_DATA = 3'h2;
  localparam logic [2:0] SRXEF_ADDR_IRQ_STAT = 3'h3;
  localparam logic [2:0] SRXEF_ADDR_IRQ_MASK = 3'h4;
  localparam logic [2:0] SRXEF_ADDR_TXDATA = 3'h5;
  // Control register fields.
  localparam int SRXEF_CTRL_RE = 0;
  localparam int SRXEF_CTRL_TE = 1;
  localparam int SRXEF_CTRL_SYNC = 2;
  localparam int SRXEF_CTRL_STOP2 = 3;
  // Status register fields.
  localparam int SRXEF_ST_RX_FULL_FLAG = 6;
  localparam int SRXEF_ST_ORER = 5;
  localparam int SRXEF_ST_FRER = 4;
  localparam int SRXEF_ST_TXBUSY = 0;
  localparam logic [7:0] SRXEF_STAT_RST = 8'h00;
  // Interrupt status/mask fields.
  localparam int SRXEF_IRQ_RXF = 0;
  localparam int SRXEF_IRQ_OVR = 1;
  localparam int SRXEF_IRQ_FRM = 2;
  localparam logic [2:0] SRXEF_IRQ_RST = 3'h0;
  // Bit timing: one bit cell is this many system clocks.
  localparam logic [7:0] SRXEF_BIT_CLKS = 8'h10;
  localparam logic [7:0] SRXEF_HALF_CLKS = 8'h08;
  localparam logic [3:0] SRXEF_DATA_BITS = 4'h8;
  localparam logic [7:0] SRXEF_DATA_RST = 8'h00;
endpackage

// *** verilog/srxef_bitclk.sv ***
`timescale 1ns/100ps
// Divider giving one-cycle bit-cell ticks; restart realigns the cell phase.
module srxef_bitclk
  import srxef_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic restart,
  input wire logic [7:0] first_cnt,
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } srxef_bc_t;
  srxef_bc_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (restart) begin
      nxt_st.cnt = first_cnt;
    end else if (st_ff.cnt == 8'h01) begin
      nxt_st.cnt = SRXEF_BIT_CLKS;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '{cnt: SRXEF_BIT_CLKS, tick: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick = st_ff.tick;
endmodule // srxef_bitclk

// *** verilog/srxef_txser.sv ***
`timescale 1ns/100ps
// Minimal transmitter: start, 8 data bits LSB first, one stop bit.
module srxef_txser
  import srxef_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic hold,
  output logic txd,
  output logic busy
);
  typedef struct packed {
    logic [9:0] sh;
    logic [3:0] cnt;
    logic busy;
    logic txd;
  } srxef_tx_t;
  srxef_tx_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (!st_ff.busy && start) begin
      nxt_st.sh = {1'b1, data, 1'b0};
      nxt_st.cnt = 4'hA;
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy && tick && !hold) begin
      nxt_st.txd = st_ff.sh[0];
      nxt_st.sh = {1'b1, st_ff.sh[9:1]};
      nxt_st.cnt = st_ff.cnt - 4'h1;
      if (st_ff.cnt == 4'h0) begin
        nxt_st.busy = 1'b0;
        nxt_st.txd = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '{sh: 10'h3FF, cnt: 4'h0, busy: 1'b0, txd: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign txd = st_ff.txd;
  assign busy = st_ff.busy;
endmodule // srxef_txser

// *** bench/srxef_rtx.sv ***
`timescale 1ns/100ps
// Remote transmitter; the line rests high between frames, as a pulled-up idle line does.
module srxef_rtx
  import srxef_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] data,
  input wire logic stop1,
  input wire logic stop2,
  input wire logic two,
  output logic rxd,
  output logic busy
);
  logic [10:0] frame;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (go) begin
      frame = {stop2, stop1, data, 1'b0};
      busy <= 1'b1;
      for (int i = 0; i < (two ? 11 : 10); i++) begin
        rxd <= frame[i];
        repeat (SRXEF_BIT_CLKS) @(posedge clk);
      end
      rxd <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule // srxef_rtx

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import srxef_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, go = 1'b0, stop1 = 1'b1, stop2 = 1'b1, two = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, rxd, txd, irq, busy;
  logic [7:0] pdata = 8'h00, b1, m_data;
  logic [31:0] seed = 32'hF983;
  int num_errors = 0, total_checks = 0, m_full = 0, m_ovr = 0, m_frm = 0, m_re = 0, lows;
  always #25 clk = ~clk;
  srxef_top i_srxef_top(.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd), .irq(irq));
  srxef_rtx i_srxef_rtx(.clk(clk), .go(go), .data(pdata), .stop1(stop1), .stop2(stop2), .two(two),
    .rxd(rxd), .busy(busy));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  // Waitrequest and read data are taken at the rising edge itself, before the slave's flops update.
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk("bus wait", 1, 0);
      end_of_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task stat();
    bus(0, SRXEF_ADDR_STAT, 0);
    chk("stat", {m_full[0], m_ovr[0], m_frm[0]}, q[6:4]);
  endtask
  task send(input logic [7:0] b, input logic s1, input logic s2, input logic tw);
    int n;
    @(posedge clk);
    pdata <= b;
    stop1 <= s1;
    stop2 <= s2;
    two <= tw;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    if (n >= 400) begin
      chk("frame wait", 1, 0);
      end_of_test();
    end
    repeat (4) @(posedge clk);
    if (m_re != 0 && m_ovr == 0 && m_frm == 0) begin
      if (!s1) begin
        m_frm = 1;
        m_data = b;
      end else if (m_full != 0) m_ovr = 1;
      else begin
        m_full = 1;
        m_data = b;
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    stat();
    bus(0, 3'h7, 0);
    chk("unmapped", 0, q);
    bus(1, SRXEF_ADDR_CTRL, 32'h1);
    m_re = 1;
    b1 = 8'(rnd());
    send(b1, 1, 1, 0);
    stat();
    chk("irq masked", 0, irq);
    bus(1, SRXEF_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    bus(1, SRXEF_ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", 0, irq);
    bus(0, SRXEF_ADDR_DATA, 0);
    chk("data", m_data, q);
    m_full = 0;
    $display("test normal done");
    b1 = 8'(rnd());
    send(b1, 1, 1, 0);
    send(8'(rnd()), 1, 1, 0);
    stat();
    send(8'(rnd()), 1, 1, 0);
    stat();
    bus(1, SRXEF_ADDR_CTRL, 32'h0);
    m_re = 0;
    stat();
    bus(1, SRXEF_ADDR_STAT, 32'hFF);
    stat();
    bus(0, SRXEF_ADDR_STAT, 0);
    bus(1, SRXEF_ADDR_STAT, 32'hDF);
    m_ovr = 0;
    stat();
    bus(0, SRXEF_ADDR_DATA, 0);
    chk("data overrun", b1, q);
    m_full = 0;
    $display("test overrun done");
    bus(1, SRXEF_ADDR_CTRL, 32'h1);
    m_re = 1;
    send(8'(rnd()), 0, 1, 0);
    stat();
    bus(0, SRXEF_ADDR_DATA, 0);
    chk("data framing", m_data, q);
    send(8'(rnd()), 1, 1, 0);
    stat();
    bus(1, SRXEF_ADDR_CTRL, 32'h7);
    bus(1, SRXEF_ADDR_TXDATA, 32'h55);
    lows = 0;
    repeat (300) begin
      @(negedge clk);
      if (txd !== 1'b1) lows++;
    end
    chk("txd low cycles", 0, lows);
    bus(1, SRXEF_ADDR_CTRL, 32'h0);
    m_re = 0;
    stat();
    bus(1, SRXEF_ADDR_STAT, 32'hFF);
    stat();
    bus(0, SRXEF_ADDR_STAT, 0);
    bus(1, SRXEF_ADDR_STAT, 32'hEF);
    m_frm = 0;
    stat();
    $display("test framing done");
    bus(1, SRXEF_ADDR_CTRL, 32'h9);
    m_re = 1;
    send(8'(rnd()), 1, 0, 1);
    stat();
    bus(0, SRXEF_ADDR_DATA, 0);
    chk("data two stop", m_data, q);
    $display("test two stop done");
    end_of_test();
  end
endmodule // tb_top
